// ### rtl/afecd_pkg.sv
// constants and types for the spi command decoder of the analog front-end
// assumes a serial link clocked by the host and a system clock inside the device
// Functional notes
// - word: addr, rw_low, sys flag, subsys, channel, code
// - burst read returns enabled channels zero to seven
// - adc register read or write codes 0x20-0xff
// - dac code zero stops waveform generator
// - dac code one starts waveform generator
// - code two forces midscale, resets slew machine
// - midscale clear ignored while generator runs
// - code three clears output faults, restores mode
// - restore abort ignored when output machine idle
// - code four clears output faults, sets float
// - float abort ignored when output machine idle
// - code five clears switch faults, closes switch
// - switch close abort ignored when idle
// - code six clears switch faults, opens switch
// - dac register read codes 0x20-0xff
// - rw_low zero marks a write
package afecd_pkg;
    localparam int unsigned CMD_W            = 16;
    localparam int unsigned BIT_DEV_ADDR     = 15;
    localparam int unsigned BIT_RW_LOW       = 14;
    localparam int unsigned BIT_SYS_FLAG     = 13;
    localparam int unsigned BIT_SUBSYS_HI    = 12;
    localparam int unsigned BIT_SUBSYS_LO    = 11;
    localparam int unsigned BIT_CH_HI        = 10;
    localparam int unsigned BIT_CH_LO        = 9;
    localparam int unsigned BIT_CODE_MSB     = 8;
    localparam int unsigned BIT_CODE_LSB     = 1;
    localparam logic [1:0] SUBSYS_ADC        = 2'h0;
    localparam logic [1:0] SUBSYS_DAC        = 2'h3;
    localparam logic [7:0] CODE_REG_FIRST    = 8'h20;
    localparam logic [7:0] CODE_BURST        = 8'h05;
    localparam logic [7:0] CODE_WAVE_STOP    = 8'h00;
    localparam logic [7:0] CODE_WAVE_START   = 8'h01;
    localparam logic [7:0] CODE_MIDSCALE     = 8'h02;
    localparam logic [7:0] CODE_OUT_RESTORE  = 8'h03;
    localparam logic [7:0] CODE_OUT_FLOAT    = 8'h04;
    localparam logic [7:0] CODE_SW_RESTORE   = 8'h05;
    localparam logic [7:0] CODE_SW_OPEN      = 8'h06;
    localparam int unsigned DAC_W            = 18;
    localparam logic [17:0] DAC_MIDSCALE     = 18'h00000;
    localparam int unsigned CHANNELS         = 8;
    localparam logic [1:0] MODE_VOLTAGE      = 2'h0;
    localparam logic [1:0] MODE_CURRENT      = 2'h1;
    localparam logic [1:0] MODE_HIGH_IMP     = 2'h2;
    localparam int unsigned DAC_WAIT_CLOCKS  = 18;
    typedef enum logic [2:0]
    {
        AFECD_OUT_IDLE  = 3'b001,
        AFECD_OUT_FAULT = 3'b010,
        AFECD_OUT_EXIT  = 3'b100
    } afecd_out_state_t;
    typedef enum logic [1:0]
    {
        AFECD_SW_IDLE  = 2'b01,
        AFECD_SW_FAULT = 2'b10
    } afecd_sw_state_t;
endpackage

// ### rtl/afecd_sync.sv
// two-flop level synchroniser
// assumes d comes from another clock domain
`timescale 1ns/1ps
module afecd_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clock,
    input  wire logic         reset,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            meta_r <= '0;
            q      <= '0;
        end
        else
        begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// ### rtl/afecd_link_rx.sv
// serial side: shifts 16 command bits on the link clock, publishes word + done flag
// assumes spi mode 0, msb first; chip select low frames; link clock stops between frames
`timescale 1ns/1ps
module afecd_link_rx
    import afecd_pkg::*;
(
    input  wire logic             link_clock,
    input  wire logic             link_cs_n,
    input  wire logic             link_mosi,
    output logic [CMD_W-1:0]      word_r,
    output logic                  word_toggle_r
);
    logic [CMD_W-1:0] shift_r;
    logic [4:0]       count_r;
    logic [CMD_W-1:0] shift_nxt;
    assign shift_nxt = {shift_r[CMD_W-2:0], link_mosi};
    // framing reset by chip select, counted only on link edges inside a frame
    always_ff @(posedge link_clock or posedge link_cs_n)
    begin
        if (link_cs_n)
        begin
            shift_r <= '0;
            count_r <= 5'h00;
        end
        else
        begin
            shift_r <= shift_nxt;
            if (count_r != 5'h1f)
                count_r <= count_r + 5'h01;
        end
    end
    always_ff @(posedge link_clock)
    begin
        if (!link_cs_n && count_r == 5'(CMD_W - 1))
            word_r <= shift_nxt;
    end
    // done flag rises half a link clock after the word settles, cleared by deselect
    always_ff @(negedge link_clock or posedge link_cs_n)
    begin
        if (link_cs_n)
            word_toggle_r <= 1'b0;
        else if (count_r == 5'(CMD_W))
            word_toggle_r <= 1'b1;
    end
endmodule

// ### rtl/afecd_top.sv
// command decoder core: decodes system command words on the system clock
// assumes host keeps the deselect wait so words arrive whole
`timescale 1ns/1ps
module afecd_top
    import afecd_pkg::*;
(
    input  wire logic                    clock,
    input  wire logic                    reset,
    input  wire logic                    link_clock,
    input  wire logic                    link_cs_n,
    input  wire logic                    link_mosi,
    input  wire logic [CHANNELS-1:0]     multichannel_enable_mask,
    input  wire logic                    output_fault_detect,
    input  wire logic                    output_short_event,
    input  wire logic                    output_overload_event,
    input  wire logic                    input_switch_short_event,
    input  wire logic                    input_switch_overload_event,
    input  wire logic [DAC_W-1:0]        user_dac_value,
    input  wire logic [1:0]              user_output_mode,
    input  wire logic                    user_mode_write,
    output logic                         waveform_running_r,
    output logic [DAC_W-1:0]             dac_value_r,
    output logic                         dac_load_r,
    output logic                         slew_reset_r,
    output logic [1:0]                   output_mode_field_r,
    output logic                         output_short_sticky_r,
    output logic                         output_overload_sticky_r,
    output logic                         input_switch_short_sticky_r,
    output logic                         input_switch_overload_sticky_r,
    output logic                         input_switch_close_bit_r,
    output logic                         current_limiter_on_r,
    output logic                         output_fsm_idle_r,
    output logic                         input_switch_fsm_idle_r,
    output logic                         burst_start_r,
    output logic [CHANNELS-1:0]          burst_channels_r,
    output logic                         reg_access_r,
    output logic                         reg_write_r,
    output logic                         reg_dac_side_r,
    output logic [7:0]                   reg_address_r,
    output logic [1:0]                   channel_r
);
    logic [CMD_W-1:0]  link_word;
    logic              link_toggle;
    logic [CMD_W-1:0]  word_s;
    logic              toggle_s;
    logic              toggle_d_r;
    logic              word_valid;
    logic              rw_low;
    logic              system_command_flag;
    logic [1:0]        subsys;
    logic [7:0]        code;
    logic              dac_write;
    logic              adc_sel;
    logic              dac_sel;
    logic              cmd_midscale;
    logic              cmd_out_restore;
    logic              cmd_out_float;
    logic              cmd_sw_restore;
    logic              cmd_sw_open;
    logic              out_exit;
    logic              sw_exit;
    logic [1:0]        prev_mode_r;
    afecd_out_state_t  out_state_r;
    afecd_sw_state_t   sw_state_r;
    logic              out_fault_s;
    logic              sw_short_s;
    logic              sw_over_s;
    logic              out_short_s;
    logic              out_over_s;

    afecd_link_rx u_rx (
        .link_clock    (link_clock),
        .link_cs_n     (link_cs_n),
        .link_mosi     (link_mosi),
        .word_r        (link_word),
        .word_toggle_r (link_toggle)
    );

    // word settles before its done flag rises, so the bus sync is safe
    afecd_sync #(.W(CMD_W + 1)) u_sync_word (
        .clock (clock),
        .reset (reset),
        .d     ({link_toggle, link_word}),
        .q     ({toggle_s, word_s})
    );

    // fault pins arrive from analog side
    afecd_sync #(.W(5)) u_sync_fault (
        .clock (clock),
        .reset (reset),
        .d     ({output_fault_detect, output_short_event, output_overload_event,
                 input_switch_short_event, input_switch_overload_event}),
        .q     ({out_fault_s, out_short_s, out_over_s, sw_short_s, sw_over_s})
    );

    always_ff @(posedge clock)
    begin
        if (reset)
            toggle_d_r <= 1'b0;
        else
            toggle_d_r <= toggle_s;
    end

    assign word_valid          = toggle_s && !toggle_d_r;
    assign rw_low              = word_s[BIT_RW_LOW];
    assign system_command_flag = word_s[BIT_SYS_FLAG];
    assign subsys              = word_s[BIT_SUBSYS_HI:BIT_SUBSYS_LO];
    assign code                = word_s[BIT_CODE_MSB:BIT_CODE_LSB];
    assign adc_sel             = word_valid && system_command_flag && subsys == SUBSYS_ADC;
    assign dac_sel             = word_valid && system_command_flag && subsys == SUBSYS_DAC;
    assign dac_write           = dac_sel && !rw_low;
    assign cmd_midscale        = dac_write && code == CODE_MIDSCALE;
    assign cmd_out_restore     = dac_write && code == CODE_OUT_RESTORE;
    assign cmd_out_float       = dac_write && code == CODE_OUT_FLOAT;
    assign cmd_sw_restore      = dac_write && code == CODE_SW_RESTORE;
    assign cmd_sw_open         = dac_write && code == CODE_SW_OPEN;
    // aborts only act on a busy machine
    assign out_exit            = (cmd_out_restore || cmd_out_float)
                                 && out_state_r != AFECD_OUT_IDLE;
    assign sw_exit             = (cmd_sw_restore || cmd_sw_open)
                                 && sw_state_r != AFECD_SW_IDLE;

    // waveform generator run flag, other codes fall through untouched
    always_ff @(posedge clock)
    begin
        if (reset)
            waveform_running_r <= 1'b0;
        else if (dac_write && code == CODE_WAVE_STOP)
            waveform_running_r <= 1'b0;
        else if (dac_write && code == CODE_WAVE_START)
            waveform_running_r <= 1'b1;
    end

    // dac value and load pulse
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            dac_value_r  <= DAC_MIDSCALE;
            dac_load_r   <= 1'b0;
            slew_reset_r <= 1'b0;
        end
        else
        begin
            dac_load_r   <= 1'b0;
            slew_reset_r <= 1'b0;
            if (cmd_midscale && !waveform_running_r)
            begin
                dac_value_r  <= DAC_MIDSCALE;
                dac_load_r   <= 1'b1;
                slew_reset_r <= 1'b1;
            end
            else if (out_exit && cmd_out_restore)
            begin
                dac_value_r <= user_dac_value;
                dac_load_r  <= 1'b1;
            end
        end
    end

    // output protection machine
    always_ff @(posedge clock)
    begin
        if (reset)
            out_state_r <= AFECD_OUT_IDLE;
        else
        begin
            case (out_state_r)
                AFECD_OUT_IDLE:
                    if (out_fault_s)
                        out_state_r <= AFECD_OUT_FAULT;
                AFECD_OUT_FAULT:
                    if (out_exit)
                        out_state_r <= AFECD_OUT_EXIT;
                AFECD_OUT_EXIT:
                    out_state_r <= AFECD_OUT_IDLE;
                default:
                    out_state_r <= AFECD_OUT_IDLE;
            endcase
        end
    end

    // output mode field; fault entry remembers the user mode
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            output_mode_field_r <= MODE_HIGH_IMP;
            prev_mode_r         <= MODE_HIGH_IMP;
        end
        else if (out_exit && cmd_out_restore)
            output_mode_field_r <= prev_mode_r;
        else if (out_exit && cmd_out_float)
            output_mode_field_r <= MODE_HIGH_IMP;
        else if (out_state_r == AFECD_OUT_IDLE && out_fault_s)
        begin
            prev_mode_r         <= output_mode_field_r;
            output_mode_field_r <= MODE_HIGH_IMP;
        end
        else if (user_mode_write)
            output_mode_field_r <= user_mode_output_mode(user_output_mode);
    end

    function automatic logic [1:0] user_mode_output_mode(input logic [1:0] m);
        user_mode_output_mode = m;
    endfunction

    // output stickies; a new event beats the abort clear
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            output_short_sticky_r    <= 1'b0;
            output_overload_sticky_r <= 1'b0;
        end
        else
        begin
            if (out_short_s)
                output_short_sticky_r <= 1'b1;
            else if (out_exit)
                output_short_sticky_r <= 1'b0;
            if (out_over_s)
                output_overload_sticky_r <= 1'b1;
            else if (out_exit)
                output_overload_sticky_r <= 1'b0;
        end
    end

    // input switch protection machine and its controls
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            sw_state_r               <= AFECD_SW_IDLE;
            input_switch_close_bit_r <= 1'b0;
            current_limiter_on_r     <= 1'b0;
        end
        else
        begin
            case (sw_state_r)
                AFECD_SW_IDLE:
                    if (sw_short_s || sw_over_s)
                    begin
                        sw_state_r           <= AFECD_SW_FAULT;
                        current_limiter_on_r <= 1'b1;
                    end
                AFECD_SW_FAULT:
                    if (sw_exit)
                    begin
                        sw_state_r           <= AFECD_SW_IDLE;
                        current_limiter_on_r <= 1'b0;
                        input_switch_close_bit_r <= cmd_sw_restore;
                    end
                default:
                    sw_state_r <= AFECD_SW_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            input_switch_short_sticky_r    <= 1'b0;
            input_switch_overload_sticky_r <= 1'b0;
        end
        else
        begin
            if (sw_short_s)
                input_switch_short_sticky_r <= 1'b1;
            else if (sw_exit)
                input_switch_short_sticky_r <= 1'b0;
            if (sw_over_s)
                input_switch_overload_sticky_r <= 1'b1;
            else if (sw_exit)
                input_switch_overload_sticky_r <= 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            output_fsm_idle_r       <= 1'b1;
            input_switch_fsm_idle_r <= 1'b1;
        end
        else
        begin
            output_fsm_idle_r       <= out_state_r == AFECD_OUT_IDLE;
            input_switch_fsm_idle_r <= sw_state_r == AFECD_SW_IDLE;
        end
    end

    // burst read and register access requests to the data path
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            burst_start_r    <= 1'b0;
            burst_channels_r <= '0;
            reg_access_r     <= 1'b0;
            reg_write_r      <= 1'b0;
            reg_dac_side_r   <= 1'b0;
            reg_address_r    <= 8'h00;
            channel_r        <= 2'h0;
        end
        else
        begin
            burst_start_r <= 1'b0;
            reg_access_r  <= 1'b0;
            if (adc_sel && rw_low && code == CODE_BURST)
            begin
                burst_start_r    <= 1'b1;
                burst_channels_r <= multichannel_enable_mask;
            end
            if ((adc_sel || (dac_sel && rw_low)) && code >= CODE_REG_FIRST)
            begin
                reg_access_r   <= 1'b1;
                reg_write_r    <= !rw_low;
                reg_dac_side_r <= dac_sel;
                reg_address_r  <= code;
                channel_r      <= word_s[BIT_CH_HI:BIT_CH_LO];
            end
        end
    end
endmodule

// ### bench/afecd_host.sv
// spi host model: frames 16-bit command words, msb first, mode 0
// assumes an 8 ns system clock in the device for the deselect wait
`timescale 1ns/1ps
module afecd_host (
    output logic link_clock,
    output logic link_cs_n,
    output logic link_mosi
);
    initial
    begin
        link_clock = 1'b0;
        link_cs_n  = 1'b1;
        link_mosi  = 1'b1;
        // blip select so the link framing starts from a known state
        #1 link_cs_n = 1'b0;
        #1 link_cs_n = 1'b1;
    end
    // callers hand listed codes, the unlisted 0x07 and one word without the system flag
    task automatic send(input logic [15:0] word);
        #1.3;
        link_cs_n = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            link_mosi = word[i];
            #3 link_clock = 1'b1;
            #3 link_clock = 1'b0;
        end
        #150;
        link_cs_n = 1'b1;
        link_mosi = ~link_mosi;
    endtask
endmodule

// ### bench/afecd_chk.sv
// checker for the command decoder core
// assumes it is bound to afecd_top and sees its ports only
`timescale 1ns/1ps
module afecd_chk
    import afecd_pkg::*;
(
    input wire logic             clock,
    input wire logic             reset,
    input wire logic             output_fault_detect,
    input wire logic             input_switch_short_event,
    input wire logic             input_switch_overload_event,
    input wire logic             user_mode_write,
    input wire logic             waveform_running_r,
    input wire logic [DAC_W-1:0] dac_value_r,
    input wire logic             slew_reset_r,
    input wire logic [1:0]       output_mode_field_r,
    input wire logic             input_switch_close_bit_r,
    input wire logic             current_limiter_on_r,
    input wire logic             output_fsm_idle_r,
    input wire logic             input_switch_fsm_idle_r,
    input wire logic             reg_access_r,
    input wire logic             reg_write_r,
    input wire logic             reg_dac_side_r,
    input wire logic [7:0]       reg_address_r
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    sequence out_quiet;
        (!output_fault_detect) [*5];
    endsequence
    sequence sw_quiet;
        (!input_switch_short_event && !input_switch_overload_event) [*5];
    endsequence
    a_midscale_blocked: assert property (
        slew_reset_r |-> !waveform_running_r) else $error("midscale while generator runs");
    a_midscale_value: assert property (
        slew_reset_r |-> ##[0:1] (dac_value_r == DAC_MIDSCALE)) else $error("dac not midscale");
    a_reg_range: assert property (
        reg_access_r |-> reg_address_r >= CODE_REG_FIRST) else $error("register address low");
    a_dac_read_only: assert property (
        reg_access_r && reg_dac_side_r |-> !reg_write_r) else $error("dac register write");
    a_out_idle_hold: assert property (
        out_quiet ##0 output_fsm_idle_r |=> output_fsm_idle_r) else $error("output fsm left idle");
    a_sw_idle_hold: assert property (
        sw_quiet ##0 input_switch_fsm_idle_r |=> input_switch_fsm_idle_r)
        else $error("switch fsm left idle");
    a_mode_hold: assert property (
        !user_mode_write ##1 output_fsm_idle_r [*2]
        |-> $past(output_mode_field_r) == $past(output_mode_field_r, 2))
        else $error("mode changed while idle");
    a_switch_hold: assert property (
        input_switch_fsm_idle_r && $past(input_switch_fsm_idle_r)
        |-> $stable(input_switch_close_bit_r)) else $error("switch bit changed while idle");
    a_limiter_off: assert property (
        sw_quiet ##0 $rose(input_switch_fsm_idle_r) |-> ##[0:1] !current_limiter_on_r)
        else $error("limiter still engaged");
endmodule

// ### bench/test_afe_spi_command_decoder.sv
// self-checking bench for the command decoder core
// assumes afecd_host drives the link and afecd_chk is bound to the core
`timescale 1ns/1ps
module test_afe_spi_command_decoder;
    import afecd_pkg::*;
    typedef struct packed {logic [15:0] word; logic hit; logic [11:0] fields;} afecd_row_t;
    logic clock = 1'b0, reset = 1'b1, link_clock, link_cs_n, link_mosi;
    logic [CHANNELS-1:0] multichannel_enable_mask = 8'h00;
    logic output_fault_detect = 1'b0, output_short_event = 1'b0, output_overload_event = 1'b0;
    logic input_switch_short_event = 1'b0, input_switch_overload_event = 1'b0;
    logic [DAC_W-1:0] user_dac_value = 18'h00000, dac_value_r;
    logic [1:0] user_output_mode = 2'h0, output_mode_field_r, channel_r;
    logic user_mode_write = 1'b0, waveform_running_r, dac_load_r, slew_reset_r;
    logic output_short_sticky_r, output_overload_sticky_r, input_switch_short_sticky_r;
    logic input_switch_overload_sticky_r, input_switch_close_bit_r, current_limiter_on_r;
    logic output_fsm_idle_r, input_switch_fsm_idle_r, burst_start_r, reg_access_r;
    logic reg_write_r, reg_dac_side_r;
    logic [CHANNELS-1:0] burst_channels_r;
    logic [7:0] reg_address_r;
    logic [11:0] acc_v;
    int n_mismatch = 0, checks_done = 0, n_acc = 0, n_burst = 0, n_slew = 0, n_load = 0, base;
    afecd_row_t rows [5];
    always #4 clock = ~clock;
    afecd_host host (.link_clock, .link_cs_n, .link_mosi);
    afecd_top DUT (.clock, .reset, .link_clock, .link_cs_n, .link_mosi,
        .multichannel_enable_mask, .output_fault_detect, .output_short_event,
        .output_overload_event, .input_switch_short_event, .input_switch_overload_event,
        .user_dac_value, .user_output_mode, .user_mode_write, .waveform_running_r,
        .dac_value_r, .dac_load_r, .slew_reset_r, .output_mode_field_r, .output_short_sticky_r,
        .output_overload_sticky_r, .input_switch_short_sticky_r,
        .input_switch_overload_sticky_r, .input_switch_close_bit_r, .current_limiter_on_r,
        .output_fsm_idle_r, .input_switch_fsm_idle_r, .burst_start_r, .burst_channels_r,
        .reg_access_r, .reg_write_r, .reg_dac_side_r, .reg_address_r, .channel_r);
    // one-clock pulses are counted where they stand
    always @(posedge clock)
    begin
        if (reg_access_r)
        begin
            n_acc++;
            acc_v = {reg_write_r, reg_dac_side_r, reg_address_r, channel_r};
        end
        if (burst_start_r) n_burst++;
        if (slew_reset_r) n_slew++;
        if (dac_load_r) n_load++;
    end
    function automatic logic [15:0] cmd(input logic rw, input logic [1:0] sub,
                                        input logic [1:0] ch, input logic [7:0] code);
        return {1'b0, rw, 1'b1, sub, ch, code, 1'b0};
    endfunction
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic issue(input logic [15:0] w);
        @(negedge clock);
        host.send(w);
        repeat (8) @(negedge clock);
    endtask
    task automatic dac_cmd(input logic [7:0] code);
        issue(cmd(1'b0, SUBSYS_DAC, 2'h0, code));
    endtask
    task automatic hit(input logic sw);
        @(negedge clock);
        {output_fault_detect, output_short_event, output_overload_event} = {3{!sw}};
        {input_switch_short_event, input_switch_overload_event} = {2{sw}};
        repeat (4) @(negedge clock);
        {output_fault_detect, output_short_event, output_overload_event} = 3'h0;
        {input_switch_short_event, input_switch_overload_event} = 2'h0;
        repeat (8) @(negedge clock);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        end_sim();
    end
    initial
    begin
        rows[0] = '{cmd(1'b1, SUBSYS_ADC, 2'h2, 8'h20), 1'b1, {2'h0, 8'h20, 2'h2}};
        rows[1] = '{cmd(1'b0, SUBSYS_ADC, 2'h1, 8'hff), 1'b1, {2'h2, 8'hff, 2'h1}};
        rows[2] = '{cmd(1'b1, SUBSYS_DAC, 2'h3, 8'h80), 1'b1, {2'h1, 8'h80, 2'h3}};
        rows[3] = '{cmd(1'b0, SUBSYS_DAC, 2'h0, 8'h20), 1'b0, 12'h000};
        rows[4] = '{cmd(1'b1, SUBSYS_ADC, 2'h0, 8'h40) & 16'hdfff, 1'b0, 12'h000};
        repeat (3) @(negedge clock);
        reset = 1'b0;
        chk("dac value", dac_value_r, DAC_MIDSCALE);
        chk("mode", output_mode_field_r, MODE_HIGH_IMP);
        chk("idle flags", {output_fsm_idle_r, input_switch_fsm_idle_r}, 2'h3);
        chk("run and close", {waveform_running_r, input_switch_close_bit_r}, 2'h0);
        foreach (rows[i])
        begin
            base = n_acc;
            issue(rows[i].word);
            chk("access count", n_acc - base, rows[i].hit);
            if (rows[i].hit) chk("access fields", acc_v, rows[i].fields);
        end
        multichannel_enable_mask = 8'ha5;
        issue(cmd(1'b1, SUBSYS_ADC, 2'h0, CODE_BURST));
        chk("burst count", n_burst, 1);
        chk("burst channels", burst_channels_r, 8'ha5);
        dac_cmd(CODE_WAVE_START);
        chk("running", waveform_running_r, 1'b1);
        base = n_slew;
        dac_cmd(CODE_MIDSCALE);
        chk("slew while running", n_slew - base, 0);
        dac_cmd(CODE_WAVE_STOP);
        chk("stopped", waveform_running_r, 1'b0);
        user_output_mode = MODE_CURRENT;
        user_dac_value = 18'h2a5a5;
        user_mode_write = 1'b1;
        @(negedge clock);
        user_mode_write = 1'b0;
        dac_cmd(CODE_OUT_RESTORE);
        dac_cmd(CODE_OUT_FLOAT);
        dac_cmd(8'h07);
        chk("idle aborts mode", output_mode_field_r, MODE_CURRENT);
        chk("idle aborts dac", dac_value_r, DAC_MIDSCALE);
        hit(1'b0);
        chk("out fault", {output_fsm_idle_r, output_short_sticky_r, output_overload_sticky_r}, 3'h3);
        dac_cmd(CODE_OUT_RESTORE);
        chk("restore stickies", {output_short_sticky_r, output_overload_sticky_r}, 2'h0);
        chk("restore mode", output_mode_field_r, MODE_CURRENT);
        chk("restore dac", dac_value_r, 18'h2a5a5);
        chk("restore idle", output_fsm_idle_r, 1'b1);
        base = n_slew;
        dac_cmd(CODE_MIDSCALE);
        chk("slew pulse", n_slew - base, 1);
        chk("midscale dac", dac_value_r, DAC_MIDSCALE);
        hit(1'b0);
        dac_cmd(CODE_OUT_FLOAT);
        chk("float stickies", {output_short_sticky_r, output_overload_sticky_r}, 2'h0);
        chk("float mode", {output_fsm_idle_r, output_mode_field_r}, {1'b1, MODE_HIGH_IMP});
        hit(1'b1);
        dac_cmd(CODE_SW_RESTORE);
        chk("sw stickies", {input_switch_short_sticky_r, input_switch_overload_sticky_r}, 2'h0);
        chk("sw close", {input_switch_close_bit_r, current_limiter_on_r}, 2'h2);
        chk("sw idle", input_switch_fsm_idle_r, 1'b1);
        dac_cmd(CODE_SW_OPEN);
        dac_cmd(CODE_SW_RESTORE);
        chk("sw idle ignore", input_switch_close_bit_r, 1'b1);
        hit(1'b1);
        dac_cmd(8'h07);
        chk("unlisted code", {input_switch_fsm_idle_r, input_switch_short_sticky_r, input_switch_overload_sticky_r}, 3'h3);
        dac_cmd(CODE_SW_OPEN);
        chk("open stickies", {input_switch_short_sticky_r, input_switch_overload_sticky_r}, 2'h0);
        chk("open bit", {input_switch_close_bit_r, input_switch_fsm_idle_r}, 2'h1);
        chk("dac loads", n_load, 2);
        end_sim();
    end
endmodule
bind afecd_top afecd_chk u_chk (.clock, .reset, .output_fault_detect,
    .input_switch_short_event, .input_switch_overload_event, .user_mode_write,
    .waveform_running_r, .dac_value_r, .slew_reset_r, .output_mode_field_r,
    .input_switch_close_bit_r, .current_limiter_on_r, .output_fsm_idle_r,
    .input_switch_fsm_idle_r, .reg_access_r, .reg_write_r, .reg_dac_side_r, .reg_address_r);
